// ===== rtl/vacuum_grip_defs.vh
// Constants shared by the vacuum grip sequencer design files
`ifndef VACUUM_GRIP_DEFS_VH
`define VACUUM_GRIP_DEFS_VH
// Mode selection codes
`define MODE_AUTO 2'b00
`define MODE_ADV 2'b01
// Object status codes
`define OBJ_UNKNOWN 2'b00
`define OBJ_MIN_SECURED 2'b01
`define OBJ_MAX_SECURED 2'b10
`define OBJ_LOST 2'b11
// Fault codes
`define FLT_NONE 4'h0
`define FLT_POROUS 4'h3
`define FLT_GRIP_TIMEOUT 4'h6
// Vacuum thresholds, percent of full scale (drop level in tenths)
`define PCT_FULL 8'h64
`define PCT_DETECT 8'h0A
`define PCT_CONTINUOUS 8'h1E
`define PERMILLE_DROP 10'h005
// Auto mode hold band margin below peak, percent
`define AUTO_BAND 8'h0A
// Timing in milliseconds
`define AUTO_GRIP_MS 2000
`define AUTO_LOW_MS 1000
`define ADV_LOW_MS 100
`define VALVE_HOLD_MS 100
// Timeout request unit, milliseconds per count
`define TIMEOUT_UNIT_MS 100
// Clock rate in kHz (250 MHz)
`define CLK_KHZ 250000
// AXI4-Lite register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_LEVELS 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_VACUUM 8'h0C
// Control register fields
`define CTRL_GO 0
`define CTRL_REL 1
`define CTRL_MODE_LO 8
// Status register fields
`define ST_OBJ_LO 0
`define ST_FLT_LO 4
`define ST_GEN 8
`define ST_VALVE 9
`define ST_DROP 10
// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ===== rtl/ms_timer.v
// Millisecond-based up counter with a running millisecond count
`timescale 1ns/1ps
module ms_timer #(
	parameter CYC_PER_MS = 250000, // Clock cycles in one millisecond
	parameter MS_W = 16 // Width of the millisecond count
) (
	// Clock and reset
	input wire ref_clk,
	input wire nrst,
	// Control
	input wire restart,
	// Result
	output reg [MS_W-1:0] ms_q
);
	reg [31:0] cyc_q; // Cycles within the current millisecond
	// Count cycles, then milliseconds; saturate so a stuck state still reads long
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cyc_q <= 32'h0;
			ms_q <= {MS_W{1'b0}};
		end else if (restart) begin
			cyc_q <= 32'h0;
			ms_q <= {MS_W{1'b0}};
		end else if (cyc_q == CYC_PER_MS - 1) begin
			cyc_q <= 32'h0;
			if (ms_q != {MS_W{1'b1}}) begin
				ms_q <= ms_q + 1'b1;
			end
		end else begin
			cyc_q <= cyc_q + 32'h1;
		end
	end
endmodule // ms_timer

// ===== rtl/axil_regs.v
// AXI4-Lite slave holding the request registers and reading back status
`timescale 1ns/1ps
`include "vacuum_grip_defs.vh"
module axil_regs (
	// Clock and reset
	input wire ref_clk,
	input wire nrst,
	// Write address and data
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// Write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// Read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Register contents
	output reg [31:0] ctrl_q,
	output reg [31:0] levels_q,
	output reg settings_wr,
	input wire [31:0] status,
	input wire [7:0] vacuum
);
	reg aw_q; // Write address held
	reg w_q; // Write data held
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg [31:0] mask;
	integer i;
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready = !w_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	// Byte mask from strobes
	always @* begin
		mask = 32'h0;
		for (i = 0; i < 4; i = i + 1) begin
			mask[i*8 +: 8] = {8{wstrb_q[i]}}; // Low byte in lane 0
		end
	end
	// Write path: address and data in either order, response after both
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 8'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			ctrl_q <= 32'h0;
			levels_q <= 32'h0;
			settings_wr <= 1'b0;
		end else begin
			settings_wr <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (aw_q && w_q) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				if (awaddr_q == `ADDR_CTRL) begin
					ctrl_q <= (ctrl_q & ~mask) | (wdata_q & mask);
					// Mode change restarts a grip like a settings write
					if (mask[`CTRL_MODE_LO] &&
						wdata_q[`CTRL_MODE_LO+1:`CTRL_MODE_LO] !=
						ctrl_q[`CTRL_MODE_LO+1:`CTRL_MODE_LO]) begin
						settings_wr <= 1'b1;
					end
				end else if (awaddr_q == `ADDR_LEVELS) begin
					levels_q <= (levels_q & ~mask) | (wdata_q & mask);
					settings_wr <= 1'b1;
				end else if (awaddr_q == `ADDR_STATUS || awaddr_q == `ADDR_VACUUM) begin
					s_axi_bresp <= `RESP_OKAY; // Read-only, write ignored
				end else begin
					s_axi_bresp <= `RESP_SLVERR; // Illegal place refused
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// Read path: one cycle from address to data
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			if (s_axi_araddr == `ADDR_CTRL) begin
				s_axi_rdata <= ctrl_q;
			end else if (s_axi_araddr == `ADDR_LEVELS) begin
				s_axi_rdata <= levels_q;
			end else if (s_axi_araddr == `ADDR_STATUS) begin
				s_axi_rdata <= status; // Status readback
			end else if (s_axi_araddr == `ADDR_VACUUM) begin
				s_axi_rdata <= {24'h0, vacuum};
			end else begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= `RESP_SLVERR; // Illegal place refused
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // axil_regs

// ===== rtl/vacuum_grip_sequencer.v
// Grip and release sequencer for a vacuum gripper, with AXI4-Lite registers
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
`include "vacuum_grip_defs.vh"
// What this block does
// - Mode 00 selects automatic, self-chosen thresholds
// - Auto grip pursues maximum vacuum, 2 s
// - Auto peak below 30% goes continuous
// - Auto steady at 30% or more: derive band, hold
// - Auto regrip: below 10% or 1 s low
// - Release: valve open, drop below 0.5%, 0.1 s
// - Mode 01 selects advanced, user settings only
// - Advanced reports 01 at min, 10 at max
// - Advanced hold alternates between secured codes
// - Advanced: below 10% or 0.1 s low ends the grip, no regrip
// - Max 100% or unreachable: continuous, no 10
// - Auto porous: no fault, run continuously
// - Advanced porous sets fault 3
// - Object lost reports status 11
// - Grip accepted sets status 00 first
// - After max, stop until min, restart
// - Advanced: no object within timeout sets fault 6
// - Retry needs go toggle; settings restart
// - Release at ambient reports 11, then close
module vacuum_grip_sequencer #(
	parameter CYC_PER_MS = `CLK_KHZ // Clock in kHz is cycles per millisecond
) (
	// Clock and reset
	input wire ref_clk,
	input wire nrst,
	// AXI4-Lite write address and data
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	// Vacuum sensing: percent of full vacuum and tenths of percent
	input wire [7:0] vacuum_pct,
	input wire [9:0] vacuum_permille,
	input wire sample_valid,
	// Robot moved away by the set distance during release
	input wire moved_away,
	// Actuators
	output reg generator_on_q,
	output reg valve_open_q
);
	localparam S_IDLE = 3'd0; // Standby
	localparam S_GRIP = 3'd1; // Pursuing maximum
	localparam S_HOLD_GEN = 3'd2; // Holding, generator running
	localparam S_HOLD_OFF = 3'd3; // Holding, generator stopped
	localparam S_CONT = 3'd4; // Continuous generation
	localparam S_REL = 3'd5; // Valve open, waiting for drop
	localparam S_REL_HOLD = 3'd6; // Valve held after drop
	localparam S_DONE = 3'd7; // Grip ended (timeout or lost)

	wire [31:0] ctrl_q; // Control register
	wire [31:0] levels_q; // Level and timeout register
	wire settings_wr; // Pulse on a settings change
	wire [15:0] ms; // Milliseconds in current phase
	wire [15:0] low_ms; // Milliseconds spent below minimum
	reg [2:0] state_q, state_d;
	reg [1:0] obj_q, obj_d;
	reg [3:0] flt_q, flt_d;
	reg drop_q, drop_d;
	reg [7:0] peak_q, peak_d; // Highest level seen in the grip
	reg [7:0] amin_q, amin_d; // Auto derived minimum
	reg [7:0] amax_q, amax_d; // Auto derived maximum
	reg [7:0] prev_q; // Previous sample for steadiness test
	reg stale_q, stale_d; // Needs go toggle or new settings
	reg gen_d, valve_d;
	reg phase_restart;
	reg low_now;
	wire go = ctrl_q[`CTRL_GO];
	wire rel_req = ctrl_q[`CTRL_REL];
	wire [1:0] mode_select = ctrl_q[`CTRL_MODE_LO+1:`CTRL_MODE_LO];
	wire [7:0] max_level_request = levels_q[7:0];
	wire [7:0] min_level_request = levels_q[15:8];
	wire [7:0] timeout_request = levels_q[23:16];
	wire is_auto = (mode_select == `MODE_AUTO);
	wire is_adv = (mode_select == `MODE_ADV);
	wire [7:0] lo_th = is_auto ? amin_q : min_level_request;
	wire [7:0] hi_th = is_auto ? amax_q : max_level_request;
	// Grip time limit in ms; advanced uses only the requested timeout
	wire [15:0] grip_ms = is_auto ? 16'd`AUTO_GRIP_MS :
		timeout_request * 16'd`TIMEOUT_UNIT_MS;
	wire [15:0] lowlim_ms = is_auto ? 16'd`AUTO_LOW_MS : 16'd`ADV_LOW_MS;
	wire steady = (vacuum_pct == prev_q) || (vacuum_pct + 8'd1 == prev_q) ||
		(prev_q + 8'd1 == vacuum_pct);

	// Register slave
	axil_regs u_regs (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.ctrl_q(ctrl_q),
		.levels_q(levels_q),
		.settings_wr(settings_wr),
		.status({21'h0, drop_q, valve_open_q, generator_on_q, flt_q, 2'b00, obj_q}),
		.vacuum(prev_q) // Last valid sample, lines carry junk between samples
	);

	// Phase timer on the own clock
	ms_timer #(.CYC_PER_MS(CYC_PER_MS), .MS_W(16)) u_phase (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.restart(phase_restart),
		.ms_q(ms)
	);

	// Time spent below the hold minimum
	ms_timer #(.CYC_PER_MS(CYC_PER_MS), .MS_W(16)) u_low (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.restart(!low_now),
		.ms_q(low_ms)
	);

	// Below-minimum only counts while holding; judged on the last valid
	// sample so idle sensor cycles do not keep restarting the timer
	always @* begin
		low_now = (state_q == S_HOLD_GEN || state_q == S_HOLD_OFF ||
			state_q == S_CONT) && (prev_q < lo_th);
	end

	// Sequencer next state
	always @* begin
		state_d = state_q;
		obj_d = obj_q;
		flt_d = flt_q;
		drop_d = drop_q;
		peak_d = peak_q;
		amin_d = amin_q;
		amax_d = amax_q;
		stale_d = stale_q;
		gen_d = 1'b0;
		valve_d = 1'b0;
		phase_restart = 1'b0;
		// Retry needs the go bit cleared, new settings also clear it
		if (!go || settings_wr) begin
			stale_d = 1'b0;
		end
		// A finished release must not start another one
		if (rel_req && go && state_q != S_REL && state_q != S_REL_HOLD &&
			state_q != S_IDLE && !(state_q == S_DONE && drop_q)) begin
			// Release from any gripping state
			state_d = S_REL;
			phase_restart = 1'b1;
			drop_d = 1'b0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (go && !rel_req && !stale_q && (is_auto || is_adv)) begin
						state_d = S_GRIP;
						obj_d = `OBJ_UNKNOWN;
						flt_d = `FLT_NONE;
						peak_d = 8'h0;
						drop_d = 1'b0;
						phase_restart = 1'b1;
					end
				end
				S_GRIP: begin
					gen_d = 1'b1;
					if (sample_valid && vacuum_pct > peak_q) begin
						peak_d = vacuum_pct;
					end
					if (is_auto) begin
						// Steady level over detect threshold sets the band
						// Steady but under 30% waits for the continuous decision
						if (sample_valid && vacuum_pct > `PCT_DETECT && steady &&
							vacuum_pct >= `PCT_CONTINUOUS &&
							ms >= 16'd`AUTO_GRIP_MS / 16'd4) begin
							amax_d = vacuum_pct;
							amin_d = (vacuum_pct > `AUTO_BAND + `PCT_DETECT) ?
								vacuum_pct - `AUTO_BAND : `PCT_DETECT;
							obj_d = `OBJ_MAX_SECURED;
							state_d = S_HOLD_OFF;
						end else if (ms >= grip_ms) begin
							// Low peak or no steady level: run continuously
							if (peak_q < `PCT_CONTINUOUS || peak_q <= `PCT_DETECT) begin
								state_d = S_CONT;
								amin_d = `PCT_DETECT;
								amax_d = `PCT_FULL;
							end else begin
								state_d = S_CONT;
								amin_d = peak_q - `AUTO_BAND;
								amax_d = `PCT_FULL;
							end
						end
					end else begin
						if (sample_valid && max_level_request < `PCT_FULL &&
							vacuum_pct >= max_level_request) begin
							obj_d = `OBJ_MAX_SECURED;
							state_d = S_HOLD_OFF;
						end else if (sample_valid && vacuum_pct >= min_level_request &&
							obj_q == `OBJ_UNKNOWN) begin
							obj_d = `OBJ_MIN_SECURED;
						end
						if (ms >= grip_ms) begin
							if (obj_q == `OBJ_MIN_SECURED) begin
								// Max not reachable: keep generating
								state_d = S_CONT;
								phase_restart = 1'b1;
							end else if (state_d == S_GRIP) begin
								flt_d = `FLT_GRIP_TIMEOUT;
								obj_d = `OBJ_LOST;
								state_d = S_DONE;
								stale_d = 1'b1;
							end
						end
					end
				end
				S_HOLD_OFF: begin
					// Generator stopped until decay to the minimum
					if (sample_valid && vacuum_pct <= lo_th) begin
						obj_d = `OBJ_MIN_SECURED;
						state_d = S_HOLD_GEN;
						phase_restart = 1'b1;
					end
				end
				S_HOLD_GEN: begin
					gen_d = 1'b1;
					if (sample_valid && vacuum_pct >= hi_th) begin
						obj_d = `OBJ_MAX_SECURED;
						state_d = S_HOLD_OFF;
						// Fast cycling hints at porous material
						if (is_adv && ms == 16'd0) begin
							flt_d = `FLT_POROUS;
						end
					end
				end
				S_CONT: begin
					gen_d = 1'b1;
					if (sample_valid && vacuum_pct >= lo_th && obj_q == `OBJ_UNKNOWN) begin
						obj_d = `OBJ_MIN_SECURED;
					end
					if (ms >= grip_ms && obj_q == `OBJ_UNKNOWN && is_adv) begin
						flt_d = `FLT_GRIP_TIMEOUT;
						obj_d = `OBJ_LOST;
						state_d = S_DONE;
						stale_d = 1'b1;
					end
				end
				S_REL: begin
					valve_d = 1'b1;
					if (sample_valid && vacuum_permille < `PERMILLE_DROP) begin
						drop_d = 1'b1;
						obj_d = `OBJ_LOST;
						state_d = S_REL_HOLD;
						phase_restart = 1'b1;
					end
				end
				S_REL_HOLD: begin
					// Close after the hold time and once the robot is clear
					if (ms >= 16'd`VALVE_HOLD_MS && moved_away) begin
						state_d = S_DONE;
					end else begin
						valve_d = 1'b1;
					end
				end
				default: begin
					// Ended grip: wait for go low or new settings
					if (!go || settings_wr || !rel_req) begin
						if (!go || settings_wr) begin
							state_d = S_IDLE;
						end
					end
				end
			endcase
		end
		// Loss while holding: below 10% or too long below minimum
		if (state_q == S_HOLD_GEN || state_q == S_HOLD_OFF ||
			(state_q == S_CONT && obj_q != `OBJ_UNKNOWN)) begin
			if ((sample_valid && vacuum_pct < `PCT_DETECT) || low_ms >= lowlim_ms) begin
				obj_d = `OBJ_LOST;
				state_d = S_DONE;
				stale_d = !is_auto;
				gen_d = 1'b0;
			end
		end
		// Auto mode regrips itself; new settings restart any grip
		if (state_q == S_DONE && is_auto && go && !rel_req && obj_q == `OBJ_LOST &&
			!drop_q) begin
			state_d = S_IDLE;
		end
		if (settings_wr && go && !rel_req && state_q != S_REL && state_q != S_REL_HOLD) begin
			state_d = S_IDLE;
			stale_d = 1'b0;
		end
	end

	// Sequencer state registers
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= S_IDLE;
			obj_q <= `OBJ_UNKNOWN;
			flt_q <= `FLT_NONE;
			drop_q <= 1'b0;
			peak_q <= 8'h0;
			amin_q <= `PCT_DETECT;
			amax_q <= `PCT_FULL;
			prev_q <= 8'h0;
			stale_q <= 1'b0;
			generator_on_q <= 1'b0;
			valve_open_q <= 1'b0;
		end else begin
			state_q <= state_d;
			obj_q <= obj_d;
			flt_q <= flt_d;
			drop_q <= drop_d;
			peak_q <= peak_d;
			amin_q <= amin_d;
			amax_q <= amax_d;
			if (sample_valid) begin
				prev_q <= vacuum_pct;
			end
			stale_q <= stale_d;
			generator_on_q <= gen_d;
			valve_open_q <= valve_d;
		end
	end
endmodule // vacuum_grip_sequencer

// ===== tb/vacuum_grip_monitor.sv
// Bus and actuator checker for the vacuum grip sequencer
`timescale 1ns/1ps
`include "vacuum_grip_defs.vh"
module vacuum_grip_monitor #(
	parameter CYC_PER_MS = 250000 // Millisecond length in cycles
) (
	// Clock and reset
	input wire ref_clk,
	input wire nrst,
	// Bus handshakes
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// Release side and actuators
	input wire moved_away,
	input wire generator_on_q,
	input wire valve_open_q
);
	// Cycles the valve has stood open
	logic [31:0] open_cnt_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Cleared when the valve shuts, so each release is timed alone
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) open_cnt_q <= 32'h0;
		else if (valve_open_q) open_cnt_q <= open_cnt_q + 32'h1;
		else open_cnt_q <= 32'h0;
	end
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_rd_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 0)
		else $error("error read with data");
	a_resp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {`RESP_OKAY, `RESP_SLVERR})
		else $error("bad write response");
	a_valve_gen: assert property (valve_open_q |-> !generator_on_q)
		else $error("generator runs while venting");
	a_valve_hold: assert property ($fell(valve_open_q) |->
		open_cnt_q >= `VALVE_HOLD_MS * CYC_PER_MS) else $error("valve closed early");
	a_close_moved: assert property ($fell(valve_open_q) |-> $past(moved_away))
		else $error("valve closed before robot cleared");
endmodule // vacuum_grip_monitor
bind vacuum_grip_sequencer vacuum_grip_monitor #(.CYC_PER_MS(CYC_PER_MS)) mon_u (
	.ref_clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .moved_away, .generator_on_q, .valve_open_q);

// ===== tb/vacuum_plant.sv
// Behavioural suction cup, pump and vent model
`timescale 1ns/1ps
module vacuum_plant (
	// Clock and reset
	input wire ref_clk,
	input wire nrst,
	// Actuators
	input wire generator_on,
	input wire valve_open,
	// Highest vacuum the load allows, percent
	input wire [7:0] ceil_pct,
	// Sensor
	output logic [7:0] vacuum_pct,
	output logic [9:0] vacuum_permille,
	output logic sample_valid
);
	// Cup vacuum in tenths of percent
	logic [9:0] lvl_q;
	// Vent outpaces pump; leak only while the pump is off
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lvl_q <= 10'h000;
			sample_valid <= 1'b0;
		end else begin
			sample_valid <= !sample_valid; // Slow sensor, every other cycle
			if (valve_open)
				lvl_q <= (lvl_q > 10'h019) ? lvl_q - 10'h019 : 10'h000;
			else if (generator_on && lvl_q < ceil_pct * 10'h00A)
				lvl_q <= lvl_q + 10'h002;
			else if (!generator_on && lvl_q != 10'h000)
				lvl_q <= lvl_q - 10'h001;
		end
	end
	// Between samples the lines carry junk, never the last value
	assign vacuum_permille = sample_valid ? lvl_q : ~lvl_q;
	assign vacuum_pct = sample_valid ? 8'(lvl_q / 10) : ~8'(lvl_q / 10);
endmodule // vacuum_plant

// ===== tb/testbench.sv
// Register-level bench for the vacuum grip sequencer
`timescale 1ns/1ps
`include "vacuum_grip_defs.vh"
module testbench;
	localparam int CYC = 4; // Short millisecond keeps the run brief
	// Clock, reset and bus requests
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	// Plant and robot side
	logic moved_away = 1'b0;
	logic [7:0] ceil_pct = 8'h00;
	wire [7:0] vacuum_pct;
	wire [9:0] vacuum_permille;
	wire sample_valid, generator_on_q, valve_open_q;
	// Results and tallies
	logic [31:0] rdat;
	logic [1:0] resp;
	int failures = 0;
	int cmp_count = 0;
	always #2 ref_clk = ~ref_clk;
	vacuum_grip_sequencer #(.CYC_PER_MS(CYC)) dut_u (.ref_clk(ref_clk), .nrst(nrst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .vacuum_pct(vacuum_pct),
		.vacuum_permille(vacuum_permille), .sample_valid(sample_valid),
		.moved_away(moved_away), .generator_on_q(generator_on_q), .valve_open_q(valve_open_q));
	vacuum_plant plant_u (.ref_clk(ref_clk), .nrst(nrst), .generator_on(generator_on_q),
		.valve_open(valve_open_q), .ceil_pct(ceil_pct), .vacuum_pct(vacuum_pct),
		.vacuum_permille(vacuum_permille), .sample_valid(sample_valid));
	// Compare one value, report a mismatch
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Write a word; each channel held until taken, decided before the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge ref_clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge ref_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
		end
	endtask
	// Read a word into rdat and resp
	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge ref_clk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			rdat = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge ref_clk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
		end
	endtask
	// Poll status until the masked field matches, then compare it
	task automatic wait_st(input logic [31:0] m, input logic [31:0] v, input int lim);
		for (int i = 0; i < lim; i++) begin
			rd(`ADDR_STATUS);
			if ((rdat & m) === v) break;
		end
		chk(rdat & m, v);
	endtask
	// Fresh start with a new load; also exercises mid-run reset
	task automatic do_reset(input logic [7:0] c);
		@(posedge ref_clk);
		nrst <= 1'b0;
		ceil_pct <= c;
		moved_away <= 1'b0;
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
	endtask
	// Verdict and end of run
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Hang guard, well beyond the longest expected run
	initial begin
		repeat (90000) @(posedge ref_clk);
		failures++;
		stop_test();
	end
	initial begin
		// Register map, read-only and unmapped places
		do_reset(8'h5A);
		rd(`ADDR_CTRL);
		chk(rdat, 32'h0);
		wr(`ADDR_LEVELS, 32'h00ABCDEF);
		rd(`ADDR_LEVELS);
		chk(rdat, 32'h00ABCDEF);
		wr(`ADDR_STATUS, 32'hFFFFFFFF);
		chk(resp, `RESP_OKAY);
		rd(`ADDR_STATUS);
		chk(rdat, 32'h0);
		rd(8'h10);
		chk(resp, `RESP_SLVERR);
		wr(8'h10, 32'h1);
		chk(resp, `RESP_SLVERR);
		// Advanced grip, band 40..60, 1 s timeout
		do_reset(8'h5A);
		wr(`ADDR_LEVELS, 32'h000A283C);
		wr(`ADDR_CTRL, 32'h00000101);
		rd(`ADDR_STATUS);
		chk(rdat[1:0], `OBJ_UNKNOWN);
		wait_st(32'h3, `OBJ_MAX_SECURED, 300);
		chk(generator_on_q, 1'b0);
		wait_st(32'h3, `OBJ_MIN_SECURED, 300);
		chk(generator_on_q, 1'b1);
		wait_st(32'h3, `OBJ_MAX_SECURED, 300);
		chk(rdat[7:4], `FLT_NONE);
		// Release: vent, drop flag, close once clear
		wr(`ADDR_CTRL, 32'h00000103);
		rd(`ADDR_STATUS);
		chk(rdat[9], 1'b1);
		wait_st(32'h403, 32'h403, 300);
		moved_away <= 1'b1;
		wait_st(32'h200, 32'h0, 400);
		// No object: timeout fault, retry by toggle and by new settings
		do_reset(8'h05);
		wr(`ADDR_LEVELS, 32'h0002283C);
		wr(`ADDR_CTRL, 32'h00000101);
		wait_st(32'hF0, 32'h60, 400);
		chk(rdat[1:0], `OBJ_LOST);
		wr(`ADDR_CTRL, 32'h00000100);
		wr(`ADDR_CTRL, 32'h00000101);
		rd(`ADDR_STATUS);
		chk(rdat[1:0], `OBJ_UNKNOWN);
		wait_st(32'hF0, 32'h60, 400);
		wr(`ADDR_LEVELS, 32'h0003283C);
		rd(`ADDR_STATUS);
		chk(rdat[1:0], `OBJ_UNKNOWN);
		// Advanced with 100% maximum: continuous, never max code
		do_reset(8'h5A);
		wr(`ADDR_LEVELS, 32'h000A2864);
		wr(`ADDR_CTRL, 32'h00000101);
		wait_st(32'h3, `OBJ_MIN_SECURED, 300);
		repeat (10 * `TIMEOUT_UNIT_MS * CYC) @(posedge ref_clk);
		rd(`ADDR_STATUS);
		chk(rdat[1:0], `OBJ_MIN_SECURED);
		chk(generator_on_q, 1'b1);
		// Automatic, weak load under 30%: continuous, no fault
		do_reset(8'h14);
		wr(`ADDR_CTRL, 32'h00000001);
		repeat ((`AUTO_GRIP_MS + 100) * CYC) @(posedge ref_clk);
		chk(generator_on_q, 1'b1);
		rd(`ADDR_STATUS);
		chk(rdat[7:4], `FLT_NONE);
		rd(`ADDR_VACUUM);
		chk(rdat, 32'h00000014);
		// Automatic, good load: band derived and held
		do_reset(8'h50);
		wr(`ADDR_CTRL, 32'h00000001);
		wait_st(32'h3, `OBJ_MIN_SECURED, 2500);
		chk(rdat[7:4], `FLT_NONE);
		stop_test();
	end
endmodule // testbench
